// File: design/ivw_regs.vh
`ifndef IVW_REGS_VH
`define IVW_REGS_VH

// Number of vector lines handled, IRQ 10 through IRQ 29
`define IVW_NLINES      20
// IRQ number of line index 0
`define IVW_FIRST_IRQ   8'h0A
// Vector address of line index 0, slots four bytes apart
`define IVW_VEC_BASE    16'h8030
`define IVW_VEC_STEP    16'h0004
// Line indices with special handling
`define IVW_SHARED_IDX  7
`define IVW_TWI_IDX     19
// Lines able to end halt or active-halt: IRQ 10-15, 18, 26, 29
`define IVW_HALT_MASK   20'h9013F
// Lines able to end wait-for-interrupt: all but IRQ 23 and 24
`define IVW_WFI_MASK    20'hF9FFF
// Lines able to end wait-for-event
`define IVW_WFE_MASK    20'hFFFFF
// Reset values
`define IVW_VEC_RST     16'h0000
`define IVW_LINES_RST   20'h00000

`endif

// File: design/ivw_map.v
// Contract
// - A wait-for-event instruction issued in low-power run puts the device in low-power wait.
// - While waiting for an event only previously enabled sources are serviced.
// - After a handler taken from wait-for-event ends, the core goes back to wait-for-event.
// - A source set up as a wakeup event ends wait-for-event and resumes without a handler.
// - The voltage detector request is OR-ed with the port E/F pin request onto one line.
// - A select input chooses whether port E or port F pins feed the shared port line.
// - The two-wire unit wakes halt or active-halt only on a match of its own address.
// - Clock switch, clock security, timer break and converter requests share IRQ 17.
`timescale 1ns/1ns
`default_nettype none
`include "ivw_regs.vh"

module ivw_map #(
	parameter NLINES = `IVW_NLINES
) (
	// Clock and reset
	input  wire              core_clk,
	input  wire              nrst,
	// Peripheral requests, IRQ 10-16 and IRQ 18-29
	input  wire [6:0]        src_lo_irq,
	input  wire [11:0]       src_hi_irq,
	// Sources sharing IRQ 17
	input  wire              clk_switch_irq,
	input  wire              clock_security_monitor_irq,
	input  wire              advanced_timer_break_irq,
	input  wire              dac_irq,
	// Shared port line sources
	input  wire              supply_voltage_detector_irq,
	input  wire              port_e_irq,
	input  wire              port_f_irq,
	input  wire              pin_port_select_ctrl,
	// Two-wire unit own-address match
	input  wire              two_wire_addr_match,
	// Per-line configuration
	input  wire [NLINES-1:0] irq_enable,
	input  wire [NLINES-1:0] event_select,
	// Core mode requests, one-cycle pulses; low_power_run is a level
	input  wire              low_power_run,
	input  wire              wait_for_event_instr,
	input  wire              wait_for_interrupt_instr,
	input  wire              halt_instr,
	input  wire              active_halt_instr,
	input  wire              handler_done,
	// Routed requests
	output reg  [NLINES-1:0] irq_lines_reg,
	output reg               port_line_irq_reg,
	output reg               irq_req_reg,
	output reg  [15:0]       vec_addr_reg,
	// Core wake and mode
	output reg               wake_isr_reg,
	output reg               wake_resume_reg,
	output reg               low_power_wait_reg,
	output reg               sleeping_reg,
	output reg  [2:0]        mode_reg
);

	localparam [2:0] ST_RUN   = 3'b000;
	localparam [2:0] ST_WFE   = 3'b001;
	localparam [2:0] ST_LPW   = 3'b010;
	localparam [2:0] ST_WFI   = 3'b011;
	localparam [2:0] ST_HALT  = 3'b100;
	localparam [2:0] ST_AHALT = 3'b101;
	localparam [2:0] ST_ISR   = 3'b110;

	reg  [2:0]        mode_next;
	reg               lp_ret_reg;
	reg               lp_ret_next;
	reg               wake_isr_next;
	reg               wake_resume_next;
	reg  [NLINES-1:0] wake_mask;
	wire [NLINES-1:0] svc;
	reg  [4:0]        first_idx;
	wire              any_svc;
	wire              sleep_next;
	wire              lpw_next;
	reg  [15:0]       vec_addr_next;
	wire              shared_line;
	wire [NLINES-1:0] lines;
	wire [NLINES-1:0] pending;
	wire [NLINES-1:0] events;
	wire [NLINES-1:0] halt_mask;
	wire              any_event;
	wire              port_line;
	integer           i;
	genvar            k;

	assign shared_line = clk_switch_irq | clock_security_monitor_irq
		| advanced_timer_break_irq | dac_irq;
	// Shared line sits between IRQ 16 and IRQ 18 so slot order follows IRQ order
	assign lines = {src_hi_irq, shared_line, src_lo_irq};
	// Port line has no wake path or vector here; it only drives port_line_irq_reg
	assign port_line = supply_voltage_detector_irq
		| (pin_port_select_ctrl ? port_f_irq : port_e_irq);

	// Event-mode lines never raise a handler
	generate
		for (k = 0; k < NLINES; k = k + 1) begin : g_line
			assign pending[k] = lines[k] & irq_enable[k] & ~event_select[k];
			assign events[k] = lines[k] & event_select[k];
			assign svc[k] = pending[k] & wake_mask[k];
		end
	endgenerate
	assign any_event = |events;
	assign any_svc = |svc;

	// Two-wire line counts for halt only on its own address
	assign halt_mask = `IVW_HALT_MASK
		& ~({{(NLINES-1){1'b0}}, ~two_wire_addr_match} << `IVW_TWI_IDX);

	// Run and handler modes use the full mask so irq_req shows any enabled line
	always @* begin
		case (mode_reg)
			ST_WFI:   wake_mask = `IVW_WFI_MASK;
			ST_HALT:  wake_mask = halt_mask;
			ST_AHALT: wake_mask = halt_mask;
			default:  wake_mask = `IVW_WFE_MASK;
		endcase
	end

	// Lowest line index wins; keeps vector order and priority aligned
	always @* begin
		first_idx = 5'h00;
		for (i = NLINES - 1; i >= 0; i = i - 1) begin
			if (svc[i]) begin
				first_idx = i[4:0];
			end
		end
	end

	// Slot address holds when no line is serviceable
	always @* begin
		vec_addr_next = vec_addr_reg;
		if (any_svc) begin
			vec_addr_next = `IVW_VEC_BASE + {9'h000, first_idx, 2'b00};
		end
	end

	// Mode requests count only in run; event wake beats handler wake
	always @* begin
		mode_next = mode_reg;
		lp_ret_next = lp_ret_reg;
		wake_isr_next = 1'b0;
		wake_resume_next = 1'b0;
		case (mode_reg)
			ST_RUN: begin
				// Priority: wait-for-event, wait-for-interrupt, halt, active-halt
				if (wait_for_event_instr) begin
					mode_next = low_power_run ? ST_LPW : ST_WFE;
				end else if (wait_for_interrupt_instr) begin
					mode_next = ST_WFI;
				end else if (halt_instr) begin
					mode_next = ST_HALT;
				end else if (active_halt_instr) begin
					mode_next = ST_AHALT;
				end
			end
			ST_WFE, ST_LPW: begin
				// Event wake wins: resuming costs no stack
				if (any_event) begin
					wake_resume_next = 1'b1;
					mode_next = ST_RUN;
				end else if (any_svc) begin
					wake_isr_next = 1'b1;
					lp_ret_next = (mode_reg == ST_LPW);
					mode_next = ST_ISR;
				end
			end
			ST_ISR: begin
				// Handler end is honoured only here
				if (handler_done) begin
					mode_next = lp_ret_reg ? ST_LPW : ST_WFE;
				end
			end
			ST_WFI, ST_HALT, ST_AHALT: begin
				// These modes wake straight into run; nothing returns them
				if (any_svc) begin
					wake_isr_next = 1'b1;
					mode_next = ST_RUN;
				end
			end
			default: begin
				mode_next = ST_RUN;
			end
		endcase
	end

	// Handler mode counts as awake although it returns to a wait state
	assign sleep_next = (mode_next != ST_RUN) && (mode_next != ST_ISR);
	assign lpw_next = (mode_next == ST_LPW);

	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			// Constants only; first edge after release samples normally
			mode_reg <= ST_RUN;
			lp_ret_reg <= 1'b0;
			wake_isr_reg <= 1'b0;
			wake_resume_reg <= 1'b0;
			low_power_wait_reg <= 1'b0;
			sleeping_reg <= 1'b0;
			irq_lines_reg <= `IVW_LINES_RST;
			port_line_irq_reg <= 1'b0;
			irq_req_reg <= 1'b0;
			vec_addr_reg <= `IVW_VEC_RST;
		end else begin
			mode_reg <= mode_next;
			lp_ret_reg <= lp_ret_next;
			wake_isr_reg <= wake_isr_next;
			wake_resume_reg <= wake_resume_next;
			low_power_wait_reg <= lpw_next;
			sleeping_reg <= sleep_next;
			irq_lines_reg <= lines;
			port_line_irq_reg <= port_line;
			irq_req_reg <= any_svc;
			vec_addr_reg <= vec_addr_next;
		end
	end

endmodule

`default_nettype wire

// File: bench/ivw_map_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ivw_map_sva (
	input wire logic core_clk, nrst, low_power_run, wait_for_event_instr, handler_done,
	input wire logic clk_switch_irq, dac_irq, two_wire_addr_match, wake_isr_reg, wake_resume_reg,
	input wire logic clock_security_monitor_irq, advanced_timer_break_irq,
	input wire logic [6:0] src_lo_irq,
	input wire logic [19:0] irq_enable, event_select, irq_lines_reg,
	input wire logic [15:0] vec_addr_reg,
	input wire logic [2:0] mode_reg);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_evt;
		(mode_reg == 3'h1 || mode_reg == 3'h2) && |(src_lo_irq & event_select[6:0]);
	endsequence
	AST_LPW: assert property (mode_reg == 3'h0 && wait_for_event_instr && low_power_run
		|=> mode_reg == 3'h2) else $error("no lpw");
	AST_EN: assert property (wake_isr_reg
		|-> |(irq_lines_reg & $past(irq_enable) & ~$past(event_select)))
		else $error("bad isr");
	AST_RET: assert property (mode_reg == 3'h6 && handler_done
		|=> mode_reg == 3'h1 || mode_reg == 3'h2) else $error("no return");
	AST_EVT: assert property (s_evt |=> wake_resume_reg && mode_reg == 3'h0)
		else $error("no resume");
	AST_SHR: assert property ($past(clk_switch_irq) || $past(dac_irq)
		|| $past(clock_security_monitor_irq) || $past(advanced_timer_break_irq)
		|-> irq_lines_reg[7]) else $error("no line 17");
	AST_HALT: assert property (wake_isr_reg && $past(mode_reg) >= 3'h4 && $past(mode_reg) <= 3'h5
		|-> |(irq_lines_reg & 20'h9013F & {$past(two_wire_addr_match), 19'h7FFFF}))
		else $error("bad halt wake");
	AST_WFI: assert property (wake_isr_reg && $past(mode_reg) == 3'h3
		|-> |(irq_lines_reg & 20'hF9FFF)) else $error("bad wfi wake");
	AST_VEC: assert property (wake_isr_reg && irq_lines_reg == 20'h80000
		|-> vec_addr_reg == 16'h807C) else $error("bad vector");
endmodule
bind ivw_map ivw_map_sva u_sva (.*);
`default_nettype wire

// File: bench/ivw_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module ivw_core_model (
	input wire logic core_clk, nrst, wake_isr_reg,
	input wire logic [2:0] mode_reg,
	output logic handler_done);
	logic [1:0] left_reg;
	// Handler runs two cycles so the core is seen in ISR first
	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst) left_reg <= 2'h0;
		else if (wake_isr_reg && mode_reg == 3'h6) left_reg <= 2'h2;
		else if (left_reg != 2'h0) left_reg <= left_reg - 2'h1;
	assign handler_done = left_reg == 2'h1;
endmodule
`default_nettype wire

// File: bench/ivw_map_test.sv
`timescale 1ns/1ns
`default_nettype none
module ivw_map_test;
	logic core_clk = 1'h0, nrst = 1'h0, low_power_run = 1'h0, wait_for_event_instr = 1'h0;
	logic wait_for_interrupt_instr = 1'h0, halt_instr = 1'h0, active_halt_instr = 1'h0;
	logic clk_switch_irq = 1'h0, clock_security_monitor_irq = 1'h0, dac_irq = 1'h0;
	logic advanced_timer_break_irq = 1'h0, supply_voltage_detector_irq = 1'h0, port_e_irq = 1'h0;
	logic port_f_irq = 1'h0, pin_port_select_ctrl = 1'h0, two_wire_addr_match = 1'h0;
	logic [6:0] src_lo_irq = 7'h00;
	logic [11:0] src_hi_irq = 12'h000;
	logic [19:0] irq_enable = 20'h00000, event_select = 20'h00000;
	wire [19:0] irq_lines_reg;
	wire [15:0] vec_addr_reg;
	wire [2:0] mode_reg;
	wire handler_done, port_line_irq_reg, irq_req_reg, wake_isr_reg, wake_resume_reg;
	wire low_power_wait_reg, sleeping_reg;
	int n_mismatch = 0, checks = 0, cycles = 0;
	ivw_map u_dut (.*);
	ivw_core_model u_core (.*);
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 900) begin
			n_mismatch++;
			print_verdict();
		end
	end
	task cyc(input int n); repeat (n) @(posedge core_clk); #10; endtask
	task automatic pulse(ref logic s); s = 1'h1; cyc(1); s = 1'h0; endtask
	task chk(input string nm, input logic [19:0] e, g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task print_verdict();
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task t_lpw();
		low_power_run = 1'h1; pulse(wait_for_event_instr);
		chk("lpw", 20'h2, mode_reg);
		chk("lpw flags", 20'h3, {low_power_wait_reg, sleeping_reg});
		src_lo_irq = 7'h08; cyc(2);
		chk("masked", 20'h2, mode_reg);
		irq_enable = 20'h00008; cyc(1);
		chk("vec", 20'h803C, wake_isr_reg ? vec_addr_reg : 16'h0000);
		chk("isr flags", 20'h1, {low_power_wait_reg, sleeping_reg, irq_req_reg});
		src_lo_irq = 7'h00; cyc(3);
		chk("back", 20'h2, mode_reg);
		chk("back flags", 20'h3, {low_power_wait_reg, sleeping_reg});
		$display("END t_lpw");
	endtask
	task t_evt();
		event_select = 20'h00020; src_lo_irq = 7'h20; cyc(1);
		chk("resume", 20'h1, {mode_reg, wake_resume_reg});
		src_lo_irq = 7'h00; event_select = 20'h00000;
		low_power_run = 1'h0; irq_enable = 20'h00008; pulse(wait_for_event_instr);
		chk("wfe", 20'h1, {low_power_wait_reg, mode_reg});
		src_lo_irq = 7'h08; cyc(1);
		chk("wfe isr", 20'h6, mode_reg);
		src_lo_irq = 7'h00; cyc(3);
		chk("wfe back", 20'h1, mode_reg);
		event_select = 20'h00020; src_lo_irq = 7'h28; cyc(1);
		chk("wfe resume", 20'h2, {mode_reg, wake_resume_reg, wake_isr_reg});
		src_lo_irq = 7'h00; event_select = 20'h00000;
		$display("END t_evt");
	endtask
	task t_port();
		for (int i = 0; i < 4; i++) begin
			pin_port_select_ctrl = i[1]; port_e_irq = i[0]; port_f_irq = ~i[0]; cyc(1);
			chk("port", {19'h0, i[0] ^ i[1]}, port_line_irq_reg);
		end
		supply_voltage_detector_irq = 1'h1; port_f_irq = 1'h0; cyc(1);
		chk("pvd", 20'h1, port_line_irq_reg);
		supply_voltage_detector_irq = 1'h0; clock_security_monitor_irq = 1'h1; cyc(1);
		chk("pvd off", 20'h0, port_line_irq_reg);
		chk("csm line", 20'h1, irq_lines_reg[7]);
		clock_security_monitor_irq = 1'h0; advanced_timer_break_irq = 1'h1; cyc(1);
		chk("brk line", 20'h1, irq_lines_reg[7]);
		advanced_timer_break_irq = 1'h0; cyc(1);
		chk("idle line", 20'h0, irq_lines_reg[7]);
		$display("END t_port");
	endtask
	task t_halt();
		pulse(halt_instr);
		clk_switch_irq = 1'h1; src_hi_irq = 12'h800; irq_enable = 20'h80080; cyc(2);
		chk("halt hold", 20'hC, {irq_lines_reg[7], mode_reg});
		chk("lines", 20'h80080, irq_lines_reg);
		clk_switch_irq = 1'h0; two_wire_addr_match = 1'h1; cyc(1);
		chk("halt wake", 20'h807C, wake_isr_reg ? vec_addr_reg : 16'h0000);
		src_hi_irq = 12'h000; two_wire_addr_match = 1'h0;
		$display("END t_halt");
	endtask
	task t_ahalt();
		pulse(active_halt_instr);
		src_lo_irq = 7'h40; src_hi_irq = 12'h002; irq_enable = 20'h00240; cyc(2);
		chk("ahalt hold", 20'h5, {irq_req_reg, mode_reg});
		src_hi_irq = 12'h102; irq_enable = 20'h10240; cyc(1);
		chk("ahalt wake", 20'h8070, wake_isr_reg ? vec_addr_reg : 16'h0000);
		src_lo_irq = 7'h00; src_hi_irq = 12'h000;
		$display("END t_ahalt");
	endtask
	task t_wfi();
		pulse(wait_for_interrupt_instr);
		src_hi_irq = 12'h020; irq_enable = 20'h02000; cyc(2);
		chk("wfi hold", 20'h3, {irq_req_reg, mode_reg});
		dac_irq = 1'h1; irq_enable = 20'h02080; cyc(1);
		chk("wfi wake", 20'h804C, wake_isr_reg ? vec_addr_reg : 16'h0000);
		chk("wfi req", 20'h1, irq_req_reg);
		dac_irq = 1'h0; src_hi_irq = 12'h000;
		$display("END t_wfi");
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		#10 nrst = 1'h1;
		t_lpw(); t_evt(); t_port(); t_halt(); t_ahalt(); t_wfi();
		print_verdict();
	end
endmodule
`default_nettype wire
